// ==== src/cfgu_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the configurable UART.
`ifndef CFGU_CFG_SVH
`define CFGU_CFG_SVH
`define CFGU_CTRL_ADDR   8'h00
`define CFGU_STAT_ADDR   8'h04
`define CFGU_RXDATA_ADDR 8'h08
`define CFGU_TXPUSH_ADDR 8'h0C
`define CFGU_CTRL_RST    32'h0000_0000
`define CFGU_F_STOPCHK   0
`define CFGU_F_IRQDIS    1
`define CFGU_F_PARITY    2
`define CFGU_F_ODD       3
`define CFGU_F_LAUNCH    4
`define CFGU_F_ACK       5
`define CFGU_F_CLKSRC    6
`define CFGU_F_PIN_LO    8
`define CFGU_F_RATE_LO   12
`define CFGU_F_CNT_LO    16
`define CFGU_CLK_HZ      125000000
`define CFGU_NRATES      11
`endif

// ==== src/cfgu_pkg.sv ====
// Types shared by the configurable UART.
package cfgu_pkg;
  typedef struct packed {
    logic [4:0] count;
    logic [3:0] rate;
    logic [1:0] pin;
    logic       clk4m;
    logic       odd;
    logic       parity;
    logic       irq_dis;
    logic       stop_chk;
  } cfgu_ctrl_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_PAR   = 3'b010,
    ST_STOP  = 3'b110
  } cfgu_state_t;
endpackage

// ==== src/cfgu_fifo.sv ====
// Send queue FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cfgu_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Fill side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
  logic         push, pop;
  assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r[AW-1:0]];
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==== src/cfgu_top.sv ====
// Configurable UART with AHB-Lite registers, send queue and selectable receive pin.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cfgu_cfg.svh"
module cfgu_top #(
  parameter int QDEPTH = 32
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        hready,
  // Serial pins.
  input  wire logic        general_pin_two,
  input  wire logic        general_pin_three,
  input  wire logic        general_pin_four,
  input  wire logic        general_pin_five,
  output logic             txd,
  // Interrupt to the DSP.
  output logic             rx_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Bit period table for both oscillator references.
  localparam int RATES [`CFGU_NRATES] = '{300, 600, 1200, 2400, 4800, 9600, 19200,
                                          38400, 57600, 76800, 115200};
  localparam int CLK = `CFGU_CLK_HZ;
  function automatic logic [19:0] bit_cycles(input logic [3:0] code, input logic c4);
    int idx;
    int rate;
    idx  = (code > 4'hA) ? 10 : int'(code);
    rate = RATES[idx];
    // The 3.6864 MHz reference, scaled by 36864/40000, divides to exact rates; the 4 MHz one truncates CLK / rate.
    if (c4) begin
      bit_cycles = 20'(CLK / rate);
    end else begin
      bit_cycles = 20'(longint'(CLK) * 36864 / (longint'(rate) * 40000));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register bus.
  cfgu_pkg::cfgu_ctrl_t ctrl_r, ctrl_nxt;
  logic       ap_wr_r, ap_wr_nxt, ap_rd_r, ap_rd_nxt;
  logic [7:0] ap_addr_r, ap_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic       launch_pulse, ack_pulse, push_valid, push_ready;
  logic       rx_flag_r, rx_flag_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic       tx_busy;
  logic [4:0] remain_r, remain_nxt;
  logic       tx_take;
  logic [7:0] q_data;
  logic       q_valid;
  logic       a_phase;
  assign a_phase   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  always_comb begin
    ap_wr_nxt    = a_phase && hwrite;
    ap_rd_nxt    = a_phase && !hwrite;
    ap_addr_nxt  = a_phase ? haddr : ap_addr_r;
    ctrl_nxt     = ctrl_r;
    launch_pulse = 1'b0;
    ack_pulse    = 1'b0;
    push_valid   = 1'b0;
    hrdata_nxt   = hrdata_r;
    if (ap_wr_r) begin
      if (ap_addr_r == `CFGU_CTRL_ADDR) begin
        ctrl_nxt.stop_chk = hwdata[`CFGU_F_STOPCHK];
        ctrl_nxt.irq_dis  = hwdata[`CFGU_F_IRQDIS];
        ctrl_nxt.parity   = hwdata[`CFGU_F_PARITY];
        ctrl_nxt.odd      = hwdata[`CFGU_F_ODD];
        ctrl_nxt.clk4m    = hwdata[`CFGU_F_CLKSRC];
        ctrl_nxt.pin      = hwdata[`CFGU_F_PIN_LO +: 2];
        ctrl_nxt.rate     = hwdata[`CFGU_F_RATE_LO +: 4];
        ctrl_nxt.count    = hwdata[`CFGU_F_CNT_LO +: 5];
        launch_pulse      = hwdata[`CFGU_F_LAUNCH];
        ack_pulse         = hwdata[`CFGU_F_ACK];
      end else if (ap_addr_r == `CFGU_TXPUSH_ADDR) begin
        push_valid = 1'b1;
      end
    end
    if (ap_rd_nxt) begin
      if (haddr == `CFGU_CTRL_ADDR) begin
        hrdata_nxt = {11'h000, ctrl_r.count, ctrl_r.rate, 2'h0, ctrl_r.pin, 1'b0,
                      ctrl_r.clk4m, 2'h0, ctrl_r.odd, ctrl_r.parity, ctrl_r.irq_dis,
                      ctrl_r.stop_chk};
      end else if (haddr == `CFGU_STAT_ADDR) begin
        hrdata_nxt = {16'h0000, 3'h0, remain_r, 4'h0, q_valid, push_ready, tx_busy,
                      rx_flag_r};
      end else if (haddr == `CFGU_RXDATA_ADDR) begin
        hrdata_nxt = {24'h000000, rx_data_r};
      end else begin
        hrdata_nxt = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= '0;
      ap_wr_r   <= 1'b0;
      ap_rd_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      ap_wr_r   <= ap_wr_nxt;
      ap_rd_r   <= ap_rd_nxt;
      ap_addr_r <= ap_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Send queue: slot zero written first is sent first.
  cfgu_fifo #(.W(8), .D(QDEPTH)) cfgu_fifo_i (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (hwdata[7:0]),
    .out_valid (q_valid),
    .out_ready (tx_take),
    .out_data  (q_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  cfgu_pkg::cfgu_state_t ts_r, ts_nxt;
  logic [19:0] tcnt_r, tcnt_nxt;
  logic [2:0]  tbit_r, tbit_nxt;
  logic [7:0]  tsh_r, tsh_nxt;
  logic        tpar_r, tpar_nxt, txd_r, txd_nxt;
  logic [19:0] period;
  assign period  = bit_cycles(ctrl_r.rate, ctrl_r.clk4m);
  assign tx_busy = (ts_r != cfgu_pkg::ST_IDLE) || (remain_r != 5'h00);
  assign txd     = txd_r;
  always_comb begin
    ts_nxt     = ts_r;
    tcnt_nxt   = tcnt_r;
    tbit_nxt   = tbit_r;
    tsh_nxt    = tsh_r;
    tpar_nxt   = tpar_r;
    txd_nxt    = txd_r;
    remain_nxt = remain_r;
    tx_take    = 1'b0;
    if (launch_pulse && !tx_busy) begin
      remain_nxt = ctrl_nxt.count;
    end
    case (ts_r)
      cfgu_pkg::ST_IDLE: begin
        txd_nxt = 1'b1;
        if (remain_r != 5'h00 && q_valid) begin
          tx_take    = 1'b1;
          remain_nxt = remain_r - 5'h01;
          tsh_nxt    = q_data;
          tpar_nxt   = ctrl_r.odd;
          txd_nxt    = 1'b0;
          tcnt_nxt   = period - 20'h00001;
          ts_nxt     = cfgu_pkg::ST_START;
        end
      end
      default: begin
        if (tcnt_r != 20'h00000) begin
          tcnt_nxt = tcnt_r - 20'h00001;
        end else begin
          tcnt_nxt = period - 20'h00001;
          case (ts_r)
            cfgu_pkg::ST_START: begin
              txd_nxt  = tsh_r[0];
              tpar_nxt = tpar_r ^ tsh_r[0];
              tsh_nxt  = {1'b0, tsh_r[7:1]};
              tbit_nxt = 3'h0;
              ts_nxt   = cfgu_pkg::ST_DATA;
            end
            cfgu_pkg::ST_DATA: begin
              if (tbit_r == 3'h7) begin
                txd_nxt = ctrl_r.parity ? tpar_r : 1'b1;
                ts_nxt  = ctrl_r.parity ? cfgu_pkg::ST_PAR : cfgu_pkg::ST_STOP;
              end else begin
                txd_nxt  = tsh_r[0];
                tpar_nxt = tpar_r ^ tsh_r[0];
                tsh_nxt  = {1'b0, tsh_r[7:1]};
                tbit_nxt = tbit_r + 3'h1;
              end
            end
            cfgu_pkg::ST_PAR: begin
              txd_nxt = 1'b1;
              ts_nxt  = cfgu_pkg::ST_STOP;
            end
            default: begin
              ts_nxt = cfgu_pkg::ST_IDLE;
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ts_r     <= cfgu_pkg::ST_IDLE;
      tcnt_r   <= 20'h00000;
      tbit_r   <= 3'h0;
      tsh_r    <= 8'h00;
      tpar_r   <= 1'b0;
      txd_r    <= 1'b1;
      remain_r <= 5'h00;
    end else begin
      ts_r     <= ts_nxt;
      tcnt_r   <= tcnt_nxt;
      tbit_r   <= tbit_nxt;
      tsh_r    <= tsh_nxt;
      tpar_r   <= tpar_nxt;
      txd_r    <= txd_nxt;
      remain_r <= remain_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive pin selection and three-stage synchroniser.
  logic       pin_sel;
  logic [2:0] rsync_r;
  logic       rxd_r, rxd_nxt;
  always_comb begin
    case (ctrl_r.pin)
      2'h0:    pin_sel = general_pin_two;
      2'h1:    pin_sel = general_pin_three;
      2'h2:    pin_sel = general_pin_four;
      default: pin_sel = general_pin_five;
    endcase
    rxd_nxt = (rsync_r[1] == rsync_r[2]) ? rsync_r[2] : rxd_r;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsync_r <= 3'b111;
      rxd_r   <= 1'b1;
    end else begin
      rsync_r <= {rsync_r[1:0], pin_sel};
      rxd_r   <= rxd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver.
  cfgu_pkg::cfgu_state_t rs_r, rs_nxt;
  logic [19:0] rcnt_r, rcnt_nxt;
  logic [2:0]  rbit_r, rbit_nxt;
  logic [7:0]  rsh_r, rsh_nxt;
  logic        rdone;
  always_comb begin
    rs_nxt      = rs_r;
    rcnt_nxt    = rcnt_r;
    rbit_nxt    = rbit_r;
    rsh_nxt     = rsh_r;
    rx_data_nxt = rx_data_r;
    rdone       = 1'b0;
    case (rs_r)
      cfgu_pkg::ST_IDLE: begin
        if (!rxd_r) begin
          rcnt_nxt = {1'b0, period[19:1]};
          rs_nxt   = cfgu_pkg::ST_START;
        end
      end
      default: begin
        if (rcnt_r != 20'h00000) begin
          rcnt_nxt = rcnt_r - 20'h00001;
        end else begin
          rcnt_nxt = period - 20'h00001;
          case (rs_r)
            cfgu_pkg::ST_START: begin
              rbit_nxt = 3'h0;
              rs_nxt   = rxd_r ? cfgu_pkg::ST_IDLE : cfgu_pkg::ST_DATA;
            end
            cfgu_pkg::ST_DATA: begin
              rsh_nxt  = {rxd_r, rsh_r[7:1]};
              rbit_nxt = rbit_r + 3'h1;
              if (rbit_r == 3'h7) begin
                rs_nxt = ctrl_r.parity ? cfgu_pkg::ST_PAR : cfgu_pkg::ST_STOP;
              end
            end
            cfgu_pkg::ST_PAR: begin
              rs_nxt = cfgu_pkg::ST_STOP;
            end
            default: begin
              rdone       = rxd_r || !ctrl_r.stop_chk;
              rx_data_nxt = rdone ? rsh_r : rx_data_r;
              rs_nxt      = cfgu_pkg::ST_IDLE;
            end
          endcase
        end
      end
    endcase
    rx_flag_nxt = rdone ? 1'b1 : (ack_pulse ? 1'b0 : rx_flag_r);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rs_r      <= cfgu_pkg::ST_IDLE;
      rcnt_r    <= 20'h00000;
      rbit_r    <= 3'h0;
      rsh_r     <= 8'h00;
      rx_data_r <= 8'h00;
      rx_flag_r <= 1'b0;
    end else begin
      rs_r      <= rs_nxt;
      rcnt_r    <= rcnt_nxt;
      rbit_r    <= rbit_nxt;
      rsh_r     <= rsh_nxt;
      rx_data_r <= rx_data_nxt;
      rx_flag_r <= rx_flag_nxt;
    end
  end
  assign rx_irq = rx_flag_r && !ctrl_r.irq_dis;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_flag_on_done: assert property (@(posedge sys_clk) disable iff (rst)
    rdone |=> rx_flag_r) else $error("receive flag not set after byte");
  a_stop_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (rs_r == cfgu_pkg::ST_STOP && rcnt_r == 20'h00000 && ctrl_r.stop_chk && !rxd_r)
    |-> !rdone) else $error("byte accepted with bad stop bit");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (rdone && !ctrl_nxt.irq_dis) |=> rx_irq) else $error("no interrupt for received byte");
  a_no_par: assert property (@(posedge sys_clk) disable iff (rst)
    (ts_r == cfgu_pkg::ST_DATA && !ctrl_r.parity) |=> ts_r != cfgu_pkg::ST_PAR)
    else $error("parity sent when disabled");
  a_par_value: assert property (@(posedge sys_clk) disable iff (rst)
    (ts_r == cfgu_pkg::ST_DATA && $past(ts_r) == cfgu_pkg::ST_DATA && tbit_r == 3'h7 &&
     tcnt_r == 20'h00000 && ctrl_r.parity) |=> txd_r == $past(tpar_r))
    else $error("parity bit wrong");
  a_launch: assert property (@(posedge sys_clk) disable iff (rst)
    (launch_pulse && !tx_busy && ctrl_nxt.count != 5'h00) |=> remain_r == $past(ctrl_nxt.count))
    else $error("launch did not load count");
  a_count_dec: assert property (@(posedge sys_clk) disable iff (rst)
    tx_take |=> remain_r == $past(remain_r) - 5'h01) else $error("byte count off");
  a_pin_map: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_r.pin == 2'h1 |-> pin_sel == general_pin_three) else $error("pin select wrong");
  a_start_low: assert property (@(posedge sys_clk) disable iff (rst)
    tx_take |=> !txd_r && ts_r == cfgu_pkg::ST_START) else $error("no start bit");
endmodule

// ==== dv/cfgu_station.sv ====
// Remote serial station: decodes frames from txd and sends frames on its line.
`timescale 1ns/1ps
module cfgu_station (
  // Clock.
  input  wire logic sys_clk,
  // Serial lines and frame settings.
  input  wire logic txd,
  input  wire logic par_en,
  input  int        bit_len,
  output logic      rxd
);
  logic [9:0] got [8];
  logic [9:0] f;
  int         ngot = 0;
  int         start_len = 0;
  int         c;
  int         k;
  int         s;
  initial rxd = 1'h1;
  // Each entry is {stop, parity, data}; bits are sampled at mid-bit on the falling clock edge.
  always begin
    @(negedge txd);
    c = 0;
    s = 0;
    k = 0;
    f = 10'h0;
    while (k < (par_en ? 10 : 9)) begin
      @(negedge sys_clk);
      c++;
      if (s == 0 && txd === 1'h1) s = c;
      if (c == bit_len * (k + 1) + bit_len / 2) begin
        f[k] = txd;
        k++;
      end
    end
    start_len = s;
    got[ngot % 8] = par_en ? f : {f[8], 1'h0, f[7:0]};
    ngot++;
  end
  // Sends start, data LSB first and a stop bit that may be bad, then one idle bit.
  task automatic send_byte(input logic [7:0] d, input logic stop);
    logic [9:0] fr;
    fr = {stop, d, 1'h0};
    for (int j = 0; j < 10; j++) begin
      rxd <= fr[j];
      repeat (bit_len) @(posedge sys_clk);
    end
    rxd <= 1'h1;
    repeat (bit_len) @(posedge sys_clk);
  endtask
endmodule

// ==== dv/config_uart_tx_rx_tb.sv ====
// Self-checking bench of the configurable UART: registers, send queue, framing, receive pins.
`timescale 1ns/1ps
`include "cfgu_cfg.svh"
module config_uart_tx_rx_tb;
  logic        sys_clk = 1'h0;
  logic        rst     = 1'h1;
  logic        hsel    = 1'h0;
  logic [7:0]  haddr   = 8'h00;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'h0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        txd;
  logic        rx_irq;
  logic        line;
  logic        par_en  = 1'h0;
  int          bit_len = 1000;
  logic [1:0]  rx_pin  = 2'h0;
  logic [31:0] rd;
  logic [7:0]  qb [5] = '{8'h11, 8'h22, 8'h31, 8'h45, 8'h77};
  int          failures = 0;
  int          comparisons = 0;

  always #4 sys_clk = ~sys_clk;

  cfgu_top #(.QDEPTH(4)) cfgu_top_i (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout),
    .general_pin_two(rx_pin == 2'h0 ? line : 1'h1),
    .general_pin_three(rx_pin == 2'h1 ? line : 1'h1),
    .general_pin_four(rx_pin == 2'h2 ? line : 1'h1),
    .general_pin_five(rx_pin == 2'h3 ? line : 1'h1),
    .txd(txd), .rx_irq(rx_irq)
  );
  cfgu_station cfgu_station_i (
    .sys_clk(sys_clk), .txd(txd), .par_en(par_en), .bit_len(bit_len), .rxd(line)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single-word transfer; entered just after a rising edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // Control word with rate code 10; b holds bits 6:0.
  function automatic logic [31:0] ctrl(input logic [1:0] pin, input logic [4:0] cnt,
                                       input logic [6:0] b);
    return {11'h0, cnt, 4'hA, 2'h0, pin, 1'h0, b};
  endfunction
  task automatic wait_got(input int n);
    for (int k = 0; k < 40000 && cfgu_station_i.ngot < n; k++) @(posedge sys_clk);
    check("frames seen", n, cfgu_station_i.ngot);
    // Frames are counted at mid stop bit; let the stop bit end so a new launch is taken.
    repeat (700) @(posedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    check("txd idle", 32'h1, {31'h0, txd});
    check("irq idle", 32'h0, {31'h0, rx_irq});
    ahb(1'h0, `CFGU_CTRL_ADDR, 32'h0);
    check("ctrl reset", `CFGU_CTRL_RST, rd);
    ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
    check("status reset", 32'h4, rd);
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(2'h3, 5'h13, 7'h4D));
    ahb(1'h1, 8'h10, 32'hFFFFFFFF);
    ahb(1'h0, 8'h10, 32'h0);
    check("unmapped read", 32'h0, rd);
    ahb(1'h0, `CFGU_CTRL_ADDR, 32'h0);
    check("ctrl readback", ctrl(2'h3, 5'h13, 7'h4D), rd);
    check("hresp", 32'h0, {31'h0, hresp});
    check("hready", 32'h1, {31'h0, hreadyout});
  endtask
  task automatic t_queue();
    for (int j = 0; j < 5; j++) ahb(1'h1, `CFGU_TXPUSH_ADDR, {24'h0, qb[j]});
    ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
    check("queue full", 32'h8, rd & 32'hC);
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(2'h0, 5'h02, 7'h10));
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(2'h0, 5'h01, 7'h10));
    wait_got(2);
    repeat (2000) @(posedge sys_clk);
    check("sent count", 32'h2, cfgu_station_i.ngot);
    check("slot zero", {22'h0, 10'h211}, {22'h0, cfgu_station_i.got[0]});
    check("slot one", {22'h0, 10'h222}, {22'h0, cfgu_station_i.got[1]});
    ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
    check("queue left", 32'hC, rd & 32'hF);
  endtask
  task automatic t_parity();
    par_en <= 1'h1;
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(2'h0, 5'h01, 7'h14));
    wait_got(3);
    check("even parity", {22'h0, 10'h331}, {22'h0, cfgu_station_i.got[2]});
    check("bit len 3M6", 32'h1, {31'h0, cfgu_station_i.start_len inside {[998:1002]}});
    bit_len <= 1085;
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(2'h0, 5'h01, 7'h5C));
    wait_got(4);
    check("odd parity", {22'h0, 10'h245}, {22'h0, cfgu_station_i.got[3]});
    check("bit len 4M", 32'h1, {31'h0, cfgu_station_i.start_len inside {[1083:1087]}});
    ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
    check("queue empty", 32'h4, rd & 32'hE);
    bit_len <= 1000;
  endtask
  // b is {irq disable, stop check}.
  task automatic t_rx(input logic [1:0] pin, input logic [1:0] b, input logic [7:0] d,
                      input logic good, input logic fl);
    rx_pin <= pin;
    ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(pin, 5'h00, {5'h0, b}));
    cfgu_station_i.send_byte(d, good);
    ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
    check("rx flag", {31'h0, fl}, rd & 32'h1);
    check("rx irq", {31'h0, fl & ~b[1]}, {31'h0, rx_irq});
    if (fl) begin
      ahb(1'h0, `CFGU_RXDATA_ADDR, 32'h0);
      check("rx data", {24'h0, d}, rd & 32'hFF);
      ahb(1'h1, `CFGU_CTRL_ADDR, ctrl(pin, 5'h00, {5'h08, b}));
      ahb(1'h0, `CFGU_STAT_ADDR, 32'h0);
      check("flag cleared", 32'h0, rd & 32'h1);
      check("irq cleared", 32'h0, {31'h0, rx_irq});
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    t_regs();
    t_queue();
    t_parity();
    t_rx(2'h0, 2'h0, 8'hA7, 1'h1, 1'h1);
    t_rx(2'h1, 2'h3, 8'h5C, 1'h1, 1'h1);
    t_rx(2'h2, 2'h1, 8'h3E, 1'h0, 1'h0);
    t_rx(2'h3, 2'h0, 8'hC1, 1'h0, 1'h1);
    complete_run();
  end
  initial begin
    repeat (98000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule
